// >>> dv/crh_core_props.sv
// Purpose: port checks for crh_core
// Assumes: bound to every crh_core instance
// Notes:   rotates are exact, shared reads span 7 to 22 clocks
`timescale 1ns/100ps
module crh_core_props
    import crh_pkg::*;
#(parameter int ADDR_W = 16) (
    input wire logic              clock,
    input wire logic              reset_n,
    input wire logic              instr_valid,
    input wire logic [31:0]       instr_word,
    input wire logic              instr_ready,
    input wire logic              instr_done,
    input wire logic              carry_flag,
    input wire logic              zero_flag,
    input wire logic [31:0]       port_a_output,
    input wire logic              hub_req,
    input wire logic [ADDR_W-1:0] hub_addr,
    input wire logic [1:0]        hub_size,
    input wire logic              hub_grant
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic go  = instr_valid && instr_ready && instr_word[21:18] == 4'hF;
    wire logic rot = go && instr_word[31:27] == 5'h06;
    wire logic rd  = go && instr_word[31:28] == 4'h0 && instr_word[27:26] != 2'h3;
    rot_timing_a: assert property (rot |=> !instr_done[*3] ##1 instr_done) else $error("rotate timing");
    read_span_a:  assert property (rd |-> ##[7:22] instr_done) else $error("read too slow");
    read_min_a:   assert property (rd |=> !instr_done[*6]) else $error("read too fast");
    done_pulse_a: assert property (instr_done |=> !instr_done) else $error("done too long");
    hub_ask_a:    assert property (rd |=> hub_req) else $error("no memory request");
    hub_hold_a:   assert property (hub_req && !hub_grant |=> hub_req && $stable(hub_addr)
        && $stable(hub_size)) else $error("request not held");
    hub_drop_a:   assert property (hub_req && hub_grant |=> !hub_req) else $error("request kept");
    read_carry_a: assert property (rd |-> ##1 $stable(carry_flag)[*7]) else $error("read moved carry");
    out_move_a:   assert property (reset_n && $changed(port_a_output) |-> instr_done) else $error("port moved");
    zero_move_a:  assert property (reset_n && $changed(zero_flag) |-> instr_done) else $error("zero moved");
endmodule : crh_core_props
bind crh_core crh_core_props #(.ADDR_W(ADDR_W)) u_props (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .instr_done(instr_done), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .port_a_output(port_a_output), .hub_req(hub_req), .hub_addr(hub_addr),
    .hub_size(hub_size), .hub_grant(hub_grant));

// >>> dv/crh_hub_model.sv
// Purpose: shared memory arbiter stand-in
// Assumes: one request open at a time
// Notes:   data outside a grant is noise so stale values never pass
`timescale 1ns/100ps
module crh_hub_model (
    input  wire logic        clock,
    input  wire logic        hub_req,
    input  wire logic [15:0] hub_addr,
    output logic             hub_grant = 1'b0,
    output logic      [31:0] hub_rdata = 32'h0
);
    int wait_cnt = -1;
    always @(posedge clock) begin
        hub_grant <= 1'b0;
        hub_rdata <= $urandom;
        if (hub_req && !hub_grant) begin
            if (wait_cnt < 0) wait_cnt = $urandom % 19;
            else if (wait_cnt == 0) begin
                hub_grant <= 1'b1;
                hub_rdata <= {16'h0, hub_addr[15:2], 2'h0} * 32'h9E3779B1;
                wait_cnt = -1;
            end else wait_cnt--;
        end
    end
endmodule : crh_hub_model

// >>> dv/tb_core_rotate_carry_hub_read.sv
// Purpose: random rotates and shared reads against a bench model
// Assumes: condition field always true
// Notes:   general registers are loaded by reads before use
`timescale 1ns/100ps
module tb_core_rotate_carry_hub_read;
    import crh_pkg::*;
    logic        clock = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, cf = 1'b0, zf = 1'b0;
    logic [31:0] instr_word = 32'h0, pa = 32'h0, pb = 32'h0, m [0:511] = '{default: SPR_RESET};
    logic        instr_done, instr_ready, carry_flag, zero_flag, hub_req, hub_grant;
    logic [31:0] last_result, po_a, po_b, pd_a, pd_b, hub_rdata;
    logic [15:0] hub_addr;
    logic [1:0]  hub_size;
    logic [5:0]  ops [5] = '{OPC_BYTE_READ, OPC_WORD_READ, OPC_LONG_READ, OPC_RCR, OPC_RCL};
    logic [8:0]  sp [6] = '{SPR_IN_A, SPR_OUT_A, SPR_DIR_B, SPR_OUT_B, SPR_DIR_A, SPR_LAUNCH};
    int          error_cnt = 0, total_checks = 0, n;
    always #5 clock = ~clock;
    crh_core uut (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_ready(instr_ready), .instr_done(instr_done), .carry_flag(carry_flag), .zero_flag(zero_flag),
        .last_result(last_result), .launch_value(pb), .port_a_pins(pa), .port_b_pins(pb),
        .port_a_direction(pd_a), .port_b_direction(pd_b), .port_a_output(po_a), .port_b_output(po_b),
        .hub_req(hub_req), .hub_addr(hub_addr), .hub_size(hub_size), .hub_grant(hub_grant), .hub_rdata(hub_rdata));
    crh_hub_model u_hub (.clock(clock), .hub_req(hub_req), .hub_addr(hub_addr), .hub_grant(hub_grant),
        .hub_rdata(hub_rdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] rv(input logic [8:0] r);
        return r == SPR_IN_A ? pa : (r == SPR_IN_B || r == SPR_LAUNCH ? pb : m[r]);
    endfunction : rv
    // Operand flags f are zero, carry, result, immediate
    task automatic run(input logic [5:0] op, input logic [3:0] f, input logic [8:0] d, input logic [8:0] s);
        logic [31:0] v, a, q;
        logic [63:0] t;
        v = rv(d);
        a = f[0] ? {23'h0, s} : rv(s);
        t = op[0] ? ({v, {32{cf}}} << a[4:0]) : ({{32{cf}}, v} >> a[4:0]);
        q = op[0] ? t[63:32] : t[31:0];
        if (op[3] && f[2]) cf = op[0] ? v[31] : v[0];
        if (!op[3]) begin
            q = {16'h0, a[15:2], 2'h0} * 32'h9E3779B1;
            q = op[1] ? q : (op[0] ? (q >> {a[1], 4'h0}) & 32'hFFFF : (q >> {a[1:0], 3'h0}) & 32'hFF);
        end
        if (f[3]) zf = (q == 32'h0);
        if (f[1] && (d < SPR_LAUNCH || d > SPR_IN_B)) m[d] = q;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= {op, f, 4'hF, d, s};
        @(posedge clock);
        instr_valid <= 1'b0;
        n = 0;
        do begin @(posedge clock); #1; n++; end while (instr_done !== 1'b1 && n < 30);
        check(last_result, q);
        check(carry_flag, cf);
        check(zero_flag, zf);
        check(po_a, m[SPR_OUT_A]);
        check(pd_b, m[SPR_DIR_B]);
        check(po_b, m[SPR_OUT_B]);
        check(pd_a, m[SPR_DIR_A]);
        if (op[3]) check(n, 3);
        else check({hub_size, hub_addr, 7'h0, n >= 6 && n <= 21}, {op[1:0], a[15:0], 8'h1});
    endtask : run
    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(32'h9FE9FE3B));
        @(posedge clock);
        pa <= $urandom;
        pb <= $urandom;
        @(posedge clock);
        reset_n <= 1'b1;
        for (int j = 0; j < 8; j++) run(OPC_LONG_READ, 4'hB, 9'(j), 9'(j * 36));
        for (int k = 0; k < 80; k++) begin
            automatic logic [3:0] f = 4'($urandom);
            run(ops[$urandom % 5], f, k % 4 == 3 ? sp[$urandom % 6] : 9'($urandom % 8),
                f[0] ? 9'($urandom) : 9'($urandom % 8));
        end
        complete_run();
    end
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule : tb_core_rotate_carry_hub_read

// >>> hdl/crh_carry_rotate.sv
// Purpose: combinational rotate through carry, left or right
// Assumes: count already limited to five bits
// Notes:   carry out is the original edge bit, independent of count
`timescale 1ns/100ps
module crh_carry_rotate (
    input  wire logic [31:0] value,
    input  wire logic [4:0]  count,
    input  wire logic        carry_in,
    input  wire logic        go_left,
    output logic      [31:0] result,
    output logic             carry_out,
    output logic             zero
);
    logic [31:0] fill_low, fill_high;

    always_comb begin
        fill_low  = ~(32'hFFFF_FFFF << count);
        fill_high = ~(32'hFFFF_FFFF >> count);
        if (go_left) begin
            result    = (value << count) | (carry_in ? fill_low : 32'h0000_0000);
            carry_out = value[31];
        end else begin
            result    = (value >> count) | (carry_in ? fill_high : 32'h0000_0000);
            carry_out = value[0];
        end
        zero = (result == 32'h0000_0000);
    end
endmodule : crh_carry_rotate

// >>> hdl/crh_core.sv
// Purpose: execution slice for carry rotates and shared-memory reads
// Assumes: arbiter raises hub_grant with hub_rdata for one cycle while hub_req is high
// Notes:   other opcodes and failed conditions retire in four clocks with no effect
`timescale 1ns/100ps
module crh_core
    import crh_pkg::*;
#(
    parameter int REG_DEPTH = 496,
    parameter int ADDR_W    = 16
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              instr_valid,
    input  wire logic [31:0]       instr_word,
    output logic                   instr_ready,
    output logic                   instr_done,
    output logic                   carry_flag,
    output logic                   zero_flag,
    output logic [31:0]            last_result,
    input  wire logic [31:0]       launch_value,
    input  wire logic [31:0]       port_a_pins,
    input  wire logic [31:0]       port_b_pins,
    output logic [31:0]            port_a_direction,
    output logic [31:0]            port_b_direction,
    output logic [31:0]            port_a_output,
    output logic [31:0]            port_b_output,
    output logic                   hub_req,
    output logic [ADDR_W-1:0]      hub_addr,
    output logic [1:0]             hub_size,
    input  wire logic              hub_grant,
    input  wire logic [31:0]       hub_rdata
);
    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    initial begin
        if (REG_DEPTH < 1 || REG_DEPTH > 496) begin
            $error("REG_DEPTH must lie in 1..496");
        end
        if (ADDR_W < 2 || ADDR_W > 32) begin
            $error("ADDR_W must lie in 2..32");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    crh_state_e        state;
    crh_state_e        next_state;
    logic [31:0]       gp_regs [REG_DEPTH];
    logic [31:0]       port_a_input;
    logic [31:0]       port_b_input;
    logic [31:0]       system_tick_count;
    logic [31:0]       next_system_tick_count;
    logic [31:0]       spr_aux [8];
    logic [31:0]       next_spr_aux [8];
    logic [31:0]       next_port_a_direction;
    logic [31:0]       next_port_b_direction;
    logic [31:0]       next_port_a_output;
    logic [31:0]       next_port_b_output;
    logic [5:0]        op;
    logic [5:0]        next_op;
    logic              do_zero;
    logic              next_do_zero;
    logic              do_carry;
    logic              next_do_carry;
    logic              do_result;
    logic              next_do_result;
    logic              live;
    logic              next_live;
    logic [8:0]        dst;
    logic [8:0]        next_dst;
    logic [31:0]       d_val;
    logic [31:0]       next_d_val;
    logic [31:0]       s_val;
    logic [31:0]       next_s_val;
    logic [4:0]        cycles;
    logic [4:0]        next_cycles;
    logic              got_data;
    logic              next_got_data;
    logic [31:0]       hub_data;
    logic [31:0]       next_hub_data;
    logic              next_instr_ready;
    logic              next_instr_done;
    logic              next_carry_flag;
    logic              next_zero_flag;
    logic [31:0]       next_last_result;
    logic              next_hub_req;
    logic [ADDR_W-1:0] next_hub_addr;
    logic [1:0]        next_hub_size;
    logic              gp_we;
    logic [8:0]        gp_waddr;
    logic [31:0]       gp_wdata;
    logic [31:0]       rot_result;
    logic              rot_carry;
    logic              rot_zero;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic cond_true(input logic [3:0] cond, input logic c, input logic z);
        cond_true = cond[{c, z}];
    endfunction : cond_true

    function automatic logic [31:0] read_operand(input logic [8:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            SPR_LAUNCH: v = launch_value;
            SPR_TICK:   v = system_tick_count;
            SPR_IN_A:   v = port_a_input;
            SPR_IN_B:   v = port_b_input;
            SPR_OUT_A:  v = port_a_output;
            SPR_OUT_B:  v = port_b_output;
            SPR_DIR_A:  v = port_a_direction;
            SPR_DIR_B:  v = port_b_direction;
            default: begin
                if (a >= SPR_CNT_A_CTRL) begin
                    v = spr_aux[a[2:0]];
                end else if (int'(a) < REG_DEPTH) begin
                    v = gp_regs[a];
                end
            end
        endcase
        return v;
    endfunction : read_operand

    function automatic logic [31:0] lane_extend(input logic [31:0] w, input logic [1:0] sz, input logic [1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (sz)
            SIZE_BYTE: v = {24'h00_0000, w[{a, 3'b000} +: 8]};
            SIZE_WORD: v = {16'h0000, w[{a[1], 4'h0} +: 16]};
            default:   v = w;
        endcase
        return v;
    endfunction : lane_extend

    // ------------------------------------------------------------
    // Pin inputs and rotator
    // ------------------------------------------------------------
    crh_sync2 #(.WIDTH(32)) u_sync_a (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in (port_a_pins),
        .sync_out (port_a_input)
    );

    crh_sync2 #(.WIDTH(32)) u_sync_b (
        .clock    (clock),
        .reset_n  (reset_n),
        .async_in (port_b_pins),
        .sync_out (port_b_input)
    );

    crh_carry_rotate u_rotate (
        .value     (d_val),
        .count     (s_val[4:0]),
        .carry_in  (carry_flag),
        .go_left   (op == OPC_RCL),
        .result    (rot_result),
        .carry_out (rot_carry),
        .zero      (rot_zero)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] value;
        logic        commit;
        value                  = 32'h0000_0000;
        commit                 = 1'b0;
        next_state             = state;
        next_op                = op;
        next_do_zero           = do_zero;
        next_do_carry          = do_carry;
        next_do_result         = do_result;
        next_live              = live;
        next_dst               = dst;
        next_d_val             = d_val;
        next_s_val             = s_val;
        next_cycles            = cycles;
        next_got_data          = got_data;
        next_hub_data          = hub_data;
        next_instr_ready       = instr_ready;
        next_instr_done        = 1'b0;
        next_carry_flag        = carry_flag;
        next_zero_flag         = zero_flag;
        next_last_result       = last_result;
        next_hub_req           = hub_req;
        next_hub_addr          = hub_addr;
        next_hub_size          = hub_size;
        next_port_a_direction  = port_a_direction;
        next_port_b_direction  = port_b_direction;
        next_port_a_output     = port_a_output;
        next_port_b_output     = port_b_output;
        next_spr_aux           = spr_aux;
        gp_we                  = 1'b0;
        gp_waddr               = dst;
        gp_wdata               = 32'h0000_0000;
        next_system_tick_count = system_tick_count + 32'h0000_0001;

        case (state)
            CRH_IDLE: begin
                if (instr_valid && instr_ready) begin
                    next_op          = instr_word[OPC_MSB:OPC_LSB];
                    next_do_zero     = instr_word[BIT_ZERO_WR];
                    next_do_carry    = instr_word[BIT_CARRY_WR];
                    next_do_result   = instr_word[BIT_RESULT];
                    next_live        = cond_true(instr_word[COND_MSB:COND_LSB], carry_flag, zero_flag);
                    next_dst         = instr_word[DST_MSB:DST_LSB];
                    next_d_val       = read_operand(instr_word[DST_MSB:DST_LSB]);
                    next_s_val       = instr_word[BIT_IMM] ? {23'h00_0000, instr_word[SRC_MSB:SRC_LSB]}
                                                           : read_operand(instr_word[SRC_MSB:SRC_LSB]);
                    next_cycles      = 5'h01;
                    next_got_data    = 1'b0;
                    next_instr_ready = 1'b0;
                    next_state       = CRH_ALU;
                    if (next_live && next_op <= OPC_LONG_READ) begin
                        next_hub_req  = 1'b1;
                        next_hub_addr = next_s_val[ADDR_W-1:0];
                        next_hub_size = next_op[1:0];
                        next_state    = CRH_HUB;
                    end
                end
            end
            CRH_ALU: begin
                next_cycles = cycles + 5'h01;
                if (cycles == ALU_CLOCKS - 5'h01) begin
                    commit = 1'b1;
                    if (live && (op == OPC_RCL || op == OPC_RCR)) begin
                        value = rot_result;
                        if (do_carry) begin
                            next_carry_flag = rot_carry;
                        end
                        if (do_zero) begin
                            next_zero_flag = rot_zero;
                        end
                    end else begin
                        commit = 1'b0;
                        next_instr_done  = 1'b1;
                        next_instr_ready = 1'b1;
                        next_state       = CRH_IDLE;
                    end
                end
            end
            CRH_HUB: begin
                if (cycles != HUB_MAX_CLK) begin
                    next_cycles = cycles + 5'h01;
                end
                if (hub_req && hub_grant) begin
                    next_hub_req  = 1'b0;
                    next_got_data = 1'b1;
                    next_hub_data = lane_extend(hub_rdata, hub_size, hub_addr[1:0]);
                end
                if (next_got_data && cycles >= HUB_MIN_CLK - 5'h01) begin
                    commit = 1'b1;
                    value  = next_hub_data;
                    if (do_zero) begin
                        next_zero_flag = (value == 32'h0000_0000);
                    end
                end
            end
            default: begin
                next_state       = CRH_IDLE;
                next_instr_ready = 1'b1;
                next_hub_req     = 1'b0;
            end
        endcase

        if (commit) begin
            next_instr_done  = 1'b1;
            next_instr_ready = 1'b1;
            next_state       = CRH_IDLE;
            next_last_result = value;
            if (do_result) begin
                gp_wdata = value;
                if (dst < SPR_LAUNCH) begin
                    gp_we = (int'(dst) < REG_DEPTH);
                end else begin
                    case (dst)
                        SPR_OUT_A:  next_port_a_output    = value;
                        SPR_OUT_B:  next_port_b_output    = value;
                        SPR_DIR_A:  next_port_a_direction = value;
                        SPR_DIR_B:  next_port_b_direction = value;
                        default: begin
                            if (dst >= SPR_CNT_A_CTRL) begin
                                next_spr_aux[dst[2:0]] = value;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // General registers carry no reset; software owns their contents
    always_ff @(posedge clock) begin
        if (gp_we) begin
            gp_regs[gp_waddr] <= gp_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state             <= CRH_IDLE;
            op                <= 6'h00;
            do_zero           <= 1'b0;
            do_carry          <= 1'b0;
            do_result         <= 1'b0;
            live              <= 1'b0;
            dst               <= 9'h000;
            d_val             <= 32'h0000_0000;
            s_val             <= 32'h0000_0000;
            cycles            <= 5'h00;
            got_data          <= 1'b0;
            hub_data          <= 32'h0000_0000;
            instr_ready       <= 1'b1;
            instr_done        <= 1'b0;
            carry_flag        <= 1'b0;
            zero_flag         <= 1'b0;
            last_result       <= 32'h0000_0000;
            hub_req           <= 1'b0;
            hub_addr          <= '0;
            hub_size          <= SIZE_BYTE;
            system_tick_count <= SPR_RESET;
            port_a_direction  <= SPR_RESET;
            port_b_direction  <= SPR_RESET;
            port_a_output     <= SPR_RESET;
            port_b_output     <= SPR_RESET;
            spr_aux           <= '{default: SPR_RESET};
        end else begin
            state             <= next_state;
            op                <= next_op;
            do_zero           <= next_do_zero;
            do_carry          <= next_do_carry;
            do_result         <= next_do_result;
            live              <= next_live;
            dst               <= next_dst;
            d_val             <= next_d_val;
            s_val             <= next_s_val;
            cycles            <= next_cycles;
            got_data          <= next_got_data;
            hub_data          <= next_hub_data;
            instr_ready       <= next_instr_ready;
            instr_done        <= next_instr_done;
            carry_flag        <= next_carry_flag;
            zero_flag         <= next_zero_flag;
            last_result       <= next_last_result;
            hub_req           <= next_hub_req;
            hub_addr          <= next_hub_addr;
            hub_size          <= next_hub_size;
            system_tick_count <= next_system_tick_count;
            port_a_direction  <= next_port_a_direction;
            port_b_direction  <= next_port_b_direction;
            port_a_output     <= next_port_a_output;
            port_b_output     <= next_port_b_output;
            spr_aux           <= next_spr_aux;
        end
    end
endmodule : crh_core

// >>> hdl/crh_pkg.sv
// Purpose: constants shared by the rotate-carry and shared-read datapath slice
// Assumes: single system clock, synchronous active-low reset
// Notes:   special register addresses are fixed slots at the top of the operand space
//
// Summary of operation
// - Carry-left shifts destination left by count, filling low bits with old carry; 4 clocks.
// - Carry-left with carry write loads carry from original destination bit 31.
// - Carry-right shifts destination right by count, filling high bits with old carry; 4 clocks.
// - Carry-right with carry write loads carry from original destination bit 0.
// - Rotate count comes from source register or 5-bit immediate, picked by immediate bit.
// - Rotates with zero write set zero flag when the result is all zeros.
// - Without result write the destination stays unchanged; requested zero flag, and carry on rotates, still update.
// - Byte read waits for memory slot, zero-extends one byte into destination.
// - Word read waits for memory slot, zero-extends a 16-bit word into destination.
// - Long read waits for memory slot and writes the full 32-bit long.
// - Each shared read takes 7 to 22 clocks depending on slot distance.
// - Shared read address comes from source register or 9-bit immediate.
// - Shared reads with zero write set zero flag when fetched value is zero.
// - Sixteen special registers are usable as ordinary destination or source operands.
// - Port inputs and system counter are read-only; writing them does nothing.
// - Direction and output registers are whole 32-bit words, one bit per pin.
// - System counter free-runs over 32 bits and software only reads it.
package crh_pkg;

    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int OPC_MSB      = 31;
    localparam int OPC_LSB      = 26;
    localparam int BIT_ZERO_WR  = 25;
    localparam int BIT_CARRY_WR = 24;
    localparam int BIT_RESULT   = 23;
    localparam int BIT_IMM      = 22;
    localparam int COND_MSB     = 21;
    localparam int COND_LSB     = 18;
    localparam int DST_MSB      = 17;
    localparam int DST_LSB      = 9;
    localparam int SRC_MSB      = 8;
    localparam int SRC_LSB      = 0;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_BYTE_READ = 6'h00;
    localparam logic [5:0] OPC_WORD_READ = 6'h01;
    localparam logic [5:0] OPC_LONG_READ = 6'h02;
    localparam logic [5:0] OPC_RCR       = 6'h0C;
    localparam logic [5:0] OPC_RCL       = 6'h0D;

    // ------------------------------------------------------------
    // Special register addresses
    // ------------------------------------------------------------
    localparam logic [8:0] SPR_LAUNCH        = 9'h1F0;
    localparam logic [8:0] SPR_TICK          = 9'h1F1;
    localparam logic [8:0] SPR_IN_A          = 9'h1F2;
    localparam logic [8:0] SPR_IN_B          = 9'h1F3;
    localparam logic [8:0] SPR_OUT_A         = 9'h1F4;
    localparam logic [8:0] SPR_OUT_B         = 9'h1F5;
    localparam logic [8:0] SPR_DIR_A         = 9'h1F6;
    localparam logic [8:0] SPR_DIR_B         = 9'h1F7;
    localparam logic [8:0] SPR_CNT_A_CTRL    = 9'h1F8;
    localparam logic [8:0] SPR_CNT_B_CTRL    = 9'h1F9;
    localparam logic [8:0] SPR_CNT_A_FREQ    = 9'h1FA;
    localparam logic [8:0] SPR_CNT_B_FREQ    = 9'h1FB;
    localparam logic [8:0] SPR_CNT_A_PHASE   = 9'h1FC;
    localparam logic [8:0] SPR_CNT_B_PHASE   = 9'h1FD;
    localparam logic [8:0] SPR_VIDEO_CFG     = 9'h1FE;
    localparam logic [8:0] SPR_VIDEO_SCALE   = 9'h1FF;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] SPR_RESET   = 32'h0000_0000;
    localparam logic [4:0]  ALU_CLOCKS  = 5'h04;
    localparam logic [4:0]  HUB_MIN_CLK = 5'h07;
    localparam logic [4:0]  HUB_MAX_CLK = 5'h16;

    // Access size toward shared memory
    localparam logic [1:0]  SIZE_BYTE = 2'h0;
    localparam logic [1:0]  SIZE_WORD = 2'h1;
    localparam logic [1:0]  SIZE_LONG = 2'h2;

    typedef enum logic [1:0] {
        CRH_IDLE = 2'b00,
        CRH_ALU  = 2'b01,
        CRH_HUB  = 2'b10
    } crh_state_e;

endpackage : crh_pkg

// >>> hdl/crh_sync2.sv
// Purpose: two-stage synchroniser for port pin inputs
// Assumes: inputs are asynchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module crh_sync2 #(
    parameter int WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule : crh_sync2
